/* verilog/sample_histogram_binner.sv */
// histogram binner with Avalon-MM register slave and 1024 x 32-bit bin RAM
// Functional notes
// - samples at or below the lower bound count in bin 0.
// - samples at or above the upper bound count in bin 1023.
// - in-range samples: subtract lower bound, multiply by scale, truncate, increment bin.
// - scale is unsigned 14-bit fraction, 0x0000 is 0.0, 0x3FFF is 16383/16384, just below 1.0.
// - 1024 bins addressed by a 10-bit index.
// - a run observes group size times group count samples.
// - group size is 16 bits, reset to 0xFFFF.
// - power measurement uses group size times power control groups [13:0].
// - bounds, scale and group count matter only in histogram mode.
// - 32-bit bin counts; overflow sets map bit 2, interrupt if mask bit 2.
// - mode 01 histograms I, 10 Q, 11 squared magnitude.
// - a run starts only on the sync event, never on a periodic timer.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
module sample_histogram_binner #(
  parameter int SAMPLE_W = 16,
  parameter int BIN_W    = 10,
  parameter int COUNT_W  = 32
) (
  input  wire logic                clk_i,            // 50 MHz clock
  input  wire logic                reset_i,          // synchronous, active high
  input  wire logic                ce_i,             // clock enable, low freezes state
  input  wire logic [8:0]          address_i,        // avalon byte address
  input  wire logic                read_i,           // avalon read
  input  wire logic                write_i,          // avalon write
  input  wire logic [3:0]          byteenable_i,     // avalon byte enables
  input  wire logic [31:0]         writedata_i,      // avalon write data
  output logic      [31:0]         readdata_o,       // avalon read data
  output logic                     waitrequest_o,    // avalon wait request
  input  wire logic [SAMPLE_W-1:0] sample_i_i,       // tapped I sample
  input  wire logic [SAMPLE_W-1:0] sample_q_i,       // tapped Q sample
  input  wire logic                sample_valid_i,   // sample strobe
  input  wire logic                twos_comp_i,      // samples are twos complement
  input  wire logic                sync_event_i,     // snapshot sync event pulse
  output logic                     irq_o,            // bin overflow interrupt
  output logic                     hist_done_o,      // run complete level
  output logic                     power_done_o      // power window complete level
);

  localparam int BINS = 1 << BIN_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0] hist_mem [BINS];

  logic [15:0] lower_r, lower_nxt, upper_r, upper_nxt, scale_r, scale_nxt;
  logic [15:0] grp_count_r, grp_count_nxt, grp_size_r, grp_size_nxt;
  logic [15:0] ctrl_r, ctrl_nxt, pwr_ctl_r, pwr_ctl_nxt;
  logic [15:0] int_map_r, int_map_nxt, int_mask_r, int_mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wait_r, wait_nxt, irq_r, irq_nxt;

  hist_binner_pkg::run_state_e state_r, state_nxt;
  logic [15:0]      samp_cnt_r, samp_cnt_nxt, grp_cnt_r, grp_cnt_nxt;
  logic [BIN_W-1:0] clr_addr_r, clr_addr_nxt, idx_r, idx_nxt;
  logic             hit_r, hit_nxt, done_r, done_nxt;
  logic [10:0]      ram_addr_r, ram_addr_nxt;

  logic        pwr_busy_r, pwr_busy_nxt, pwr_done_r, pwr_done_nxt;
  logic [15:0] pwr_samp_r, pwr_samp_nxt;
  logic [13:0] pwr_grp_r, pwr_grp_nxt;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [6:0]  reg_idx;
  logic        wr_acc, rd_acc;
  logic [15:0] wval, rd_word;
  logic [COUNT_W-1:0] ram_word;
  logic [1:0]  cmd;

  assign reg_idx  = address_i[8:2];
  // request is completed on the edge where waitrequest is seen low
  assign wr_acc   = write_i && !wait_r;
  assign rd_acc   = read_i && !wait_r;
  assign ram_word = hist_mem[ram_addr_r[10:1]];
  assign cmd      = writedata_i[hist_binner_pkg::CMD_LSB +: 2];

  // ----------------------------------------------------------------
  // sample source and bin index
  // ----------------------------------------------------------------
  hist_binner_pkg::mode_e mode;
  logic signed [2*SAMPLE_W+1:0] i_x, q_x;
  logic        [2*SAMPLE_W+1:0] mag_sq;
  logic        [SAMPLE_W-1:0]   src_val;
  logic                         src_signed;
  logic        [BIN_W-1:0]      bin_idx;

  always_comb begin
    mode   = hist_binner_pkg::mode_e'(ctrl_r[hist_binner_pkg::MODE_LSB +: 2]);
    // widened before squaring: a 17-bit product would wrap
    i_x    = (2*SAMPLE_W+2)'(signed'({twos_comp_i & sample_i_i[SAMPLE_W-1], sample_i_i}));
    q_x    = (2*SAMPLE_W+2)'(signed'({twos_comp_i & sample_q_i[SAMPLE_W-1], sample_q_i}));
    mag_sq = $unsigned(i_x * i_x) + $unsigned(q_x * q_x);
    src_signed = twos_comp_i;
    unique case (mode)
      hist_binner_pkg::MODE_HIST_Q: src_val = sample_q_i;
      hist_binner_pkg::MODE_HIST_MAG: begin
        // magnitude squared is never negative; keep its top 16 bits
        src_signed = 1'b0;
        src_val = twos_comp_i ? mag_sq[2*SAMPLE_W-1 -: SAMPLE_W]
                              : mag_sq[2*SAMPLE_W -: SAMPLE_W];
      end
      default: src_val = sample_i_i;
    endcase
  end

  hist_bin_index #(
    .VAL_W  (SAMPLE_W),
    .IDX_W  (BIN_W),
    .FRAC_W (hist_binner_pkg::SCALE_W)
  ) u_index (
    .value_i  (src_val),
    .signed_i (src_signed),
    .lower_i  (lower_r),
    .upper_i  (upper_r),
    .scale_i  (scale_r[hist_binner_pkg::SCALE_W-1:0]),
    .index_o  (bin_idx)
  );

  // ----------------------------------------------------------------
  // register file and bus answer
  // ----------------------------------------------------------------
  logic ovf_evt;
  assign ovf_evt = hit_r && (hist_mem[idx_r] == {COUNT_W{1'b1}});

  always_comb begin
    lower_nxt     = lower_r;
    upper_nxt     = upper_r;
    scale_nxt     = scale_r;
    grp_count_nxt = grp_count_r;
    grp_size_nxt  = grp_size_r;
    ctrl_nxt      = ctrl_r;
    pwr_ctl_nxt   = pwr_ctl_r;
    int_mask_nxt  = int_mask_r;
    int_map_nxt   = int_map_r;
    rdata_nxt     = rdata_r;
    wait_nxt      = 1'b1;
    wval = '0;
    wval[7:0]  = byteenable_i[0] ? writedata_i[7:0] : 8'h00;
    wval[15:8] = byteenable_i[1] ? writedata_i[15:8] : 8'h00;
    unique case (reg_idx)
      hist_binner_pkg::IDX_CONTROL:       rd_word = ctrl_r;
      hist_binner_pkg::IDX_STATUS:        rd_word = {13'h0000, state_r};
      hist_binner_pkg::IDX_RAM_ADDRESS:   rd_word = {5'h00, ram_addr_r};
      hist_binner_pkg::IDX_RAM_DATA:      rd_word = ram_addr_r[0] ? ram_word[15:0]
                                                                  : ram_word[31:16];
      hist_binner_pkg::IDX_LOWER_BOUND:   rd_word = lower_r;
      hist_binner_pkg::IDX_UPPER_BOUND:   rd_word = upper_r;
      hist_binner_pkg::IDX_INDEX_SCALE:   rd_word = scale_r;
      hist_binner_pkg::IDX_GROUP_COUNT:   rd_word = grp_count_r;
      hist_binner_pkg::IDX_INT_MAP:       rd_word = int_map_r;
      hist_binner_pkg::IDX_INT_MASK:      rd_word = int_mask_r;
      hist_binner_pkg::IDX_POWER_STATUS:  rd_word = {14'h0000, pwr_done_r, pwr_busy_r};
      hist_binner_pkg::IDX_POWER_CONTROL: rd_word = pwr_ctl_r;
      hist_binner_pkg::IDX_GROUP_SIZE:    rd_word = grp_size_r;
      default:                            rd_word = 16'h0000;
    endcase
    if ((read_i || write_i) && wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = {16'h0000, rd_word};
    end
    if (wr_acc) begin
      unique case (reg_idx)
        hist_binner_pkg::IDX_CONTROL:       ctrl_nxt = wval & hist_binner_pkg::CONTROL_MASK;
        hist_binner_pkg::IDX_LOWER_BOUND:   lower_nxt = wval;
        hist_binner_pkg::IDX_UPPER_BOUND:   upper_nxt = wval;
        hist_binner_pkg::IDX_INDEX_SCALE:   scale_nxt = {2'b00, wval[13:0]};
        hist_binner_pkg::IDX_GROUP_COUNT:   grp_count_nxt = wval;
        hist_binner_pkg::IDX_INT_MASK:      int_mask_nxt = wval;
        hist_binner_pkg::IDX_INT_MAP:       int_map_nxt = int_map_r & ~wval;
        hist_binner_pkg::IDX_POWER_CONTROL: pwr_ctl_nxt = wval;
        hist_binner_pkg::IDX_GROUP_SIZE:    grp_size_nxt = wval;
        default: ;
      endcase
    end
    // an overflow in the clearing cycle still lands: set beats clear
    if (ovf_evt) begin
      int_map_nxt[hist_binner_pkg::OVF_BIT] = 1'b1;
    end
    irq_nxt = int_map_nxt[hist_binner_pkg::OVF_BIT]
            & int_mask_nxt[hist_binner_pkg::OVF_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lower_r     <= hist_binner_pkg::RST_LOWER_BOUND;
      upper_r     <= hist_binner_pkg::RST_UPPER_BOUND;
      scale_r     <= hist_binner_pkg::RST_INDEX_SCALE;
      grp_count_r <= hist_binner_pkg::RST_GROUP_COUNT;
      grp_size_r  <= hist_binner_pkg::RST_GROUP_SIZE;
      ctrl_r      <= hist_binner_pkg::RST_CONTROL;
      pwr_ctl_r   <= hist_binner_pkg::RST_POWER_CONTROL;
      int_mask_r  <= 16'h0000;
      int_map_r   <= 16'h0000;
      rdata_r     <= 32'h0000_0000;
      wait_r      <= 1'b1;
      irq_r       <= 1'b0;
    end else if (ce_i) begin
      lower_r     <= lower_nxt;
      upper_r     <= upper_nxt;
      scale_r     <= scale_nxt;
      grp_count_r <= grp_count_nxt;
      grp_size_r  <= grp_size_nxt;
      ctrl_r      <= ctrl_nxt;
      pwr_ctl_r   <= pwr_ctl_nxt;
      int_mask_r  <= int_mask_nxt;
      int_map_r   <= int_map_nxt;
      rdata_r     <= rdata_nxt;
      wait_r      <= wait_nxt;
      irq_r       <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // run control, bin update and clearing
  // ----------------------------------------------------------------
  logic               ctrl_wr, last_samp, last_grp, run_empty;
  logic               mem_we;
  logic [BIN_W-1:0]   mem_wa;
  logic [COUNT_W-1:0] mem_wd;

  always_comb begin
    state_nxt    = state_r;
    samp_cnt_nxt = samp_cnt_r;
    grp_cnt_nxt  = grp_cnt_r;
    clr_addr_nxt = clr_addr_r;
    ram_addr_nxt = ram_addr_r;
    idx_nxt      = bin_idx;
    hit_nxt      = 1'b0;
    ctrl_wr   = wr_acc && (reg_idx == hist_binner_pkg::IDX_CONTROL);
    last_samp = (samp_cnt_r == grp_size_r - 16'h0001);
    last_grp  = (grp_cnt_r == grp_count_r - 16'h0001);
    run_empty = (grp_size_r == 16'h0000) || (grp_count_r == 16'h0000);
    if ((wr_acc || rd_acc) && (reg_idx == hist_binner_pkg::IDX_RAM_DATA)) begin
      ram_addr_nxt = ram_addr_r + 11'h001;
    end
    unique case (state_r)
      hist_binner_pkg::ST_WAITING: begin
        // capture mode leaves the binner idle, the settings unused
        if (sync_event_i && (mode != hist_binner_pkg::MODE_CAPTURE)) begin
          samp_cnt_nxt = 16'h0000;
          grp_cnt_nxt  = 16'h0000;
          state_nxt = run_empty ? hist_binner_pkg::ST_DONE
                                : hist_binner_pkg::ST_ACTIVE;
        end
      end
      hist_binner_pkg::ST_ACTIVE: begin
        if (sample_valid_i) begin
          hit_nxt = 1'b1;
          if (last_samp) begin
            samp_cnt_nxt = 16'h0000;
            grp_cnt_nxt  = grp_cnt_r + 16'h0001;
            if (last_grp) begin
              state_nxt = hist_binner_pkg::ST_DONE;
            end
          end else begin
            samp_cnt_nxt = samp_cnt_r + 16'h0001;
          end
        end
      end
      hist_binner_pkg::ST_CLEARING: begin
        clr_addr_nxt = clr_addr_r + 1'b1;
        if (clr_addr_r == {BIN_W{1'b1}}) begin
          state_nxt = hist_binner_pkg::ST_OFF;
        end
      end
      default: ;
    endcase
    if (ctrl_wr) begin
      ram_addr_nxt = 11'h000;
      unique case (hist_binner_pkg::cmd_e'(cmd))
        hist_binner_pkg::CMD_DISABLE: state_nxt = hist_binner_pkg::ST_OFF;
        hist_binner_pkg::CMD_ENABLE:  state_nxt = hist_binner_pkg::ST_WAITING;
        default: begin
          state_nxt    = hist_binner_pkg::ST_CLEARING;
          clr_addr_nxt = '0;
        end
      endcase
    end
    done_nxt = (state_nxt == hist_binner_pkg::ST_DONE);
    // clearing owns the write port; a late increment is dropped
    if (state_r == hist_binner_pkg::ST_CLEARING) begin
      mem_we = 1'b1;
      mem_wa = clr_addr_r;
      mem_wd = '0;
    end else begin
      mem_we = hit_r;
      mem_wa = idx_r;
      mem_wd = hist_mem[idx_r] + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && mem_we) begin
      hist_mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r    <= hist_binner_pkg::ST_OFF;
      samp_cnt_r <= 16'h0000;
      grp_cnt_r  <= 16'h0000;
      clr_addr_r <= '0;
      ram_addr_r <= 11'h000;
      idx_r      <= '0;
      hit_r      <= 1'b0;
      done_r     <= 1'b0;
    end else if (ce_i) begin
      state_r    <= state_nxt;
      samp_cnt_r <= samp_cnt_nxt;
      grp_cnt_r  <= grp_cnt_nxt;
      clr_addr_r <= clr_addr_nxt;
      ram_addr_r <= ram_addr_nxt;
      idx_r      <= idx_nxt;
      hit_r      <= hit_nxt;
      done_r     <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power measurement window
  // ----------------------------------------------------------------
  logic pwr_wr;

  always_comb begin
    pwr_busy_nxt = pwr_busy_r;
    pwr_done_nxt = pwr_done_r;
    pwr_samp_nxt = pwr_samp_r;
    pwr_grp_nxt  = pwr_grp_r;
    pwr_wr = wr_acc && (reg_idx == hist_binner_pkg::IDX_POWER_CONTROL);
    if (pwr_wr) begin
      pwr_samp_nxt = 16'h0000;
      pwr_grp_nxt  = 14'h0000;
      pwr_done_nxt = 1'b0;
      pwr_busy_nxt = (wval[hist_binner_pkg::PWR_GROUPS_W-1:0] != 14'h0000)
                  && (grp_size_r != 16'h0000);
    end else if (pwr_busy_r && sample_valid_i) begin
      if (pwr_samp_r == grp_size_r - 16'h0001) begin
        pwr_samp_nxt = 16'h0000;
        pwr_grp_nxt  = pwr_grp_r + 14'h0001;
        if (pwr_grp_r == pwr_ctl_r[hist_binner_pkg::PWR_GROUPS_W-1:0] - 14'h0001) begin
          pwr_busy_nxt = 1'b0;
          pwr_done_nxt = 1'b1;
        end
      end else begin
        pwr_samp_nxt = pwr_samp_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwr_busy_r <= 1'b0;
      pwr_done_r <= 1'b0;
      pwr_samp_r <= 16'h0000;
      pwr_grp_r  <= 14'h0000;
    end else if (ce_i) begin
      pwr_busy_r <= pwr_busy_nxt;
      pwr_done_r <= pwr_done_nxt;
      pwr_samp_r <= pwr_samp_nxt;
      pwr_grp_r  <= pwr_grp_nxt;
    end
  end

  assign readdata_o    = rdata_r;
  assign waitrequest_o = wait_r;
  assign irq_o         = irq_r;
  assign hist_done_o   = done_r;
  assign power_done_o  = pwr_done_r;

endmodule

/* verilog/hist_binner_pkg.sv */
// constants and types shared by the histogram binner files
package hist_binner_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [6:0] IDX_CONTROL       = 7'h70;
  localparam logic [6:0] IDX_STATUS        = 7'h71;
  localparam logic [6:0] IDX_RAM_ADDRESS   = 7'h72;
  localparam logic [6:0] IDX_RAM_DATA      = 7'h73;
  localparam logic [6:0] IDX_LOWER_BOUND   = 7'h74;
  localparam logic [6:0] IDX_UPPER_BOUND   = 7'h75;
  localparam logic [6:0] IDX_INDEX_SCALE   = 7'h76;
  localparam logic [6:0] IDX_GROUP_COUNT   = 7'h77;
  localparam logic [6:0] IDX_INT_MAP       = 7'h78;
  localparam logic [6:0] IDX_INT_MASK      = 7'h79;
  localparam logic [6:0] IDX_POWER_STATUS  = 7'h7D;
  localparam logic [6:0] IDX_POWER_CONTROL = 7'h7E;
  localparam logic [6:0] IDX_GROUP_SIZE    = 7'h7F;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_LOWER_BOUND   = 16'h0000;
  localparam logic [15:0] RST_UPPER_BOUND   = 16'h0000;
  localparam logic [15:0] RST_INDEX_SCALE   = 16'h0000;
  localparam logic [15:0] RST_GROUP_COUNT   = 16'h0000;
  localparam logic [15:0] RST_GROUP_SIZE    = 16'hFFFF;
  localparam logic [15:0] RST_CONTROL       = 16'h0000;
  localparam logic [15:0] RST_POWER_CONTROL = 16'h0000;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int          SCALE_W       = 14;
  localparam int          PWR_GROUPS_W  = 14;
  localparam int          OVF_BIT       = 2;
  localparam logic [15:0] CONTROL_MASK  = 16'h00FF;
  localparam int          CMD_LSB       = 0;
  localparam int          MODE_LSB      = 6;

  typedef enum logic [1:0] {
    CMD_DISABLE = 2'b00,
    CMD_ENABLE  = 2'b01,
    CMD_CLEAR   = 2'b10,
    CMD_CLEAR2  = 2'b11
  } cmd_e;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_HIST_I  = 2'b01,
    MODE_HIST_Q  = 2'b10,
    MODE_HIST_MAG = 2'b11
  } mode_e;

  typedef enum logic [2:0] {
    ST_OFF      = 3'b000,
    ST_WAITING  = 3'b001,
    ST_ACTIVE   = 3'b010,
    ST_DONE     = 3'b011,
    ST_CLEARING = 3'b100
  } run_state_e;

endpackage

/* verilog/hist_bin_index.sv */
// clamp, offset and scale one sample into a histogram bin index
`timescale 1ns/10ps
module hist_bin_index #(
  parameter int VAL_W  = 16,
  parameter int IDX_W  = 10,
  parameter int FRAC_W = 14
) (
  input  wire logic [VAL_W-1:0]  value_i,   // sample value
  input  wire logic              signed_i,  // value and bounds are twos complement
  input  wire logic [VAL_W-1:0]  lower_i,   // lower bound
  input  wire logic [VAL_W-1:0]  upper_i,   // upper bound
  input  wire logic [FRAC_W-1:0] scale_i,   // fractional scale
  output logic      [IDX_W-1:0]  index_o    // bin index
);

  logic signed [VAL_W:0]        val_x;
  logic signed [VAL_W:0]        low_x;
  logic signed [VAL_W:0]        up_x;
  logic        [VAL_W:0]        diff;
  logic        [VAL_W+FRAC_W-1:0] prod;

  // one extra bit lets one signed compare serve both formats
  always_comb begin
    val_x = {signed_i & value_i[VAL_W-1], value_i};
    low_x = {signed_i & lower_i[VAL_W-1], lower_i};
    up_x  = {signed_i & upper_i[VAL_W-1], upper_i};
    diff  = val_x - low_x;
    prod  = diff[VAL_W-1:0] * scale_i;
    if (val_x <= low_x) begin
      index_o = '0;
    end else if (val_x >= up_x) begin
      index_o = '1;
    end else begin
      // truncation: fraction bits dropped, upper bits out of range ignored
      index_o = prod[FRAC_W +: IDX_W];
    end
  end

endmodule

/* tb/hist_binner_properties.sv */
// port assertions for the histogram binner
`timescale 1ns/10ps
module hist_binner_properties (
  input wire logic        clk_i,          // clock
  input wire logic        reset_i,        // sync reset
  input wire logic        ce_i,           // clock enable
  input wire logic [8:0]  address_i,      // byte address
  input wire logic        read_i,         // bus read
  input wire logic        write_i,        // bus write
  input wire logic [31:0] readdata_o,     // read data
  input wire logic        waitrequest_o,  // wait request
  input wire logic        irq_o,          // interrupt
  input wire logic        hist_done_o,    // run complete
  input wire logic        power_done_o    // power window complete
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // bus handshake and control outputs
  // ----------------------------------------------------------------
  a_wait_answers: assert property (
    ce_i && (read_i || write_i) && waitrequest_o |=> !waitrequest_o) else $error("no answer");
  a_wait_one_cycle: assert property (
    ce_i && !waitrequest_o |=> waitrequest_o) else $error("wait low too long");
  a_wait_idle_high: assert property (
    ce_i && !read_i && !write_i && waitrequest_o |=> waitrequest_o) else $error("spurious answer");
  a_rdata_holds: assert property (
    !(waitrequest_o && (read_i || write_i)) |=> $stable(readdata_o)) else $error("data moved");
  a_rdata_upper_zero: assert property (
    readdata_o[31:16] == 16'h0000) else $error("upper read half not zero");
  // a stalled enable must not let any status flag move
  a_freeze_outputs: assert property (
    !ce_i |=> $stable({hist_done_o, irq_o, waitrequest_o, power_done_o})) else $error("froze");
  a_done_holds: assert property (
    hist_done_o && !write_i |=> hist_done_o) else $error("done dropped without a write");
  a_done_cleared: assert property (
    write_i && !waitrequest_o && address_i[8:2] == hist_binner_pkg::IDX_CONTROL
    |=> !hist_done_o) else $error("done kept after control write");
  a_power_restart: assert property (
    write_i && !waitrequest_o && address_i[8:2] == hist_binner_pkg::IDX_POWER_CONTROL
    |=> !power_done_o) else $error("power done kept after restart");
endmodule
bind sample_histogram_binner hist_binner_properties u_props (
  .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
  .hist_done_o(hist_done_o), .power_done_o(power_done_o));

/* tb/sample_tap_model.sv */
// sample tap model standing in for the internal signal chain
`timescale 1ns/10ps
module sample_tap_model (
  input  wire logic        clk_i,    // clock
  input  wire logic        go_i,     // present one sample
  input  wire logic [15:0] value_i,  // sample to present
  output logic      [15:0] i_o,      // I tap
  output logic      [15:0] q_o,      // Q tap
  output logic             valid_o   // one-cycle strobe
);
  // between strobes the I tap shows the inverse, so stale data never looks valid; the Q tap shows the inverse at the strobe
  always_ff @(posedge clk_i) begin
    valid_o <= go_i;
    i_o     <= go_i ? value_i : ~value_i;
    q_o     <= go_i ? ~value_i : value_i;
  end
endmodule

/* tb/testbench.sv */
// self-checking bench for the histogram binner
`timescale 1ns/10ps
module testbench;
  typedef struct {logic wr; logic [6:0] idx; logic [15:0] wd; logic [31:0] exp;} row_s;
  logic        clk_i, reset_i, ce_i, read_i, write_i, sync_event_i, tap_go, tc;
  logic        waitrequest_o, irq_o, hist_done_o, power_done_o, sample_valid_i;
  logic [8:0]  address_i;
  logic [15:0] tap_val, sample_i_i, sample_q_i;
  logic [31:0] writedata_i, readdata_o, rd;
  int          error_cnt, compares, a;
  row_s        rows[16];

  sample_histogram_binner u_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .byteenable_i(4'hf),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .sample_i_i(sample_i_i), .sample_q_i(sample_q_i), .sample_valid_i(sample_valid_i),
    .twos_comp_i(tc), .sync_event_i(sync_event_i), .irq_o(irq_o),
    .hist_done_o(hist_done_o), .power_done_o(power_done_o));
  sample_tap_model u_tap (.clk_i(clk_i), .go_i(tap_go), .value_i(tap_val), .i_o(sample_i_i),
    .q_o(sample_q_i), .valid_o(sample_valid_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one idle edge after release keeps back-to-back calls from double driving
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    address_i   <= {idx, 2'b00};
    writedata_i <= {16'h0000, wd};
    write_i     <= wr;
    read_i      <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    rd = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
    if (n == 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  task automatic poll(input logic [2:0] want);
    int n;
    n = 0;
    do begin
      bus(1'b0, hist_binner_pkg::IDX_STATUS, 16'h0000);
      n++;
    end while (rd[2:0] !== want && n < 1000);
    check(rd, {29'h0000_0000, want});
    if (n == 1000) print_verdict();
  endtask
  task automatic send(input logic [15:0] v);
    tap_val <= v;
    tap_go  <= 1'b1;
    @(posedge clk_i);
    tap_go  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic sync_pulse();
    sync_event_i <= 1'b1;
    @(posedge clk_i);
    sync_event_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] bin_count(input int bin);
    case (bin)
      0, 100: bin_count = 16'h0002;
      449, 1023: bin_count = 16'h0001;
      default: bin_count = 16'h0000;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    read_i = 1'b0;
    write_i = 1'b0;
    sync_event_i = 1'b0;
    tap_go = 1'b0;
    tc = 1'b0;
    tap_val = 16'h0000;
    address_i = 9'h000;
    writedata_i = 32'h0000_0000;
    rows = '{
      '{1'b0, hist_binner_pkg::IDX_GROUP_SIZE, 16'h0000, 32'h0000_ffff},
      '{1'b0, hist_binner_pkg::IDX_INDEX_SCALE, 16'h0000, 32'h0000_0000},
      '{1'b0, hist_binner_pkg::IDX_STATUS, 16'h0000, 32'h0000_0000},
      '{1'b1, 7'h10, 16'h1234, 32'h0000_0000},
      '{1'b0, 7'h10, 16'h0000, 32'h0000_0000},
      '{1'b1, hist_binner_pkg::IDX_INDEX_SCALE, 16'hffff, 32'h0000_0000},
      '{1'b0, hist_binner_pkg::IDX_INDEX_SCALE, 16'h0000, 32'h0000_3fff},
      '{1'b1, hist_binner_pkg::IDX_GROUP_SIZE, 16'h0002, 32'h0000_0000},
      '{1'b1, hist_binner_pkg::IDX_GROUP_COUNT, 16'h0003, 32'h0000_0000},
      '{1'b0, hist_binner_pkg::IDX_GROUP_COUNT, 16'h0000, 32'h0000_0003},
      '{1'b1, hist_binner_pkg::IDX_LOWER_BOUND, 16'h0064, 32'h0000_0000},
      '{1'b1, hist_binner_pkg::IDX_UPPER_BOUND, 16'h03e8, 32'h0000_0000},
      '{1'b1, hist_binner_pkg::IDX_INDEX_SCALE, 16'h2000, 32'h0000_0000},
      '{1'b1, hist_binner_pkg::IDX_INT_MASK, 16'h0004, 32'h0000_0000},
      '{1'b0, hist_binner_pkg::IDX_INT_MASK, 16'h0000, 32'h0000_0004},
      '{1'b1, hist_binner_pkg::IDX_POWER_CONTROL, 16'h0001, 32'h0000_0000}};
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].idx, rows[i].wd);
      if (!rows[i].wr) check(rd, rows[i].exp);
    end
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0002);
    bus(1'b0, hist_binner_pkg::IDX_STATUS, 16'h0000);
    check(rd, 32'h0000_0004);
    poll(3'h0);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0001);
    sync_pulse();
    poll(3'h1);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0041);
    send(16'h012c);
    check({31'h0000_0000, power_done_o}, 32'h0000_0000);
    poll(3'h1);
    sync_pulse();
    poll(3'h2);
    send(16'h0028);
    send(16'h0064);
    send(16'h03e8);
    send(16'h03e7);
    send(16'h012c);
    send(16'h012d);
    poll(3'h3);
    check({31'h0000_0000, power_done_o}, 32'h0000_0001);
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    check({31'h0000_0000, hist_done_o}, 32'h0000_0001);
    send(16'h012c);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    @(posedge clk_i);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0000);
    check({31'h0000_0000, hist_done_o}, 32'h0000_0000);
    for (a = 0; a < 2048; a++) begin
      bus(1'b0, hist_binner_pkg::IDX_RAM_DATA, 16'h0000);
      check(rd, a[0] ? {16'h0000, bin_count(a / 2)} : 32'h0000_0000);
    end
    // signed Q run: -1 lands in bin 7, unsigned or I decode would not
    tc <= 1'b1;
    bus(1'b1, hist_binner_pkg::IDX_LOWER_BOUND, 16'hfff0);
    bus(1'b1, hist_binner_pkg::IDX_UPPER_BOUND, 16'h0010);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0002);
    poll(3'h0);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0081);
    sync_pulse();
    send(16'h0000);
    bus(1'b1, hist_binner_pkg::IDX_CONTROL, 16'h0000);
    for (a = 0; a < 18; a++) begin
      bus(1'b0, hist_binner_pkg::IDX_RAM_DATA, 16'h0000);
      check(rd, (a == 15) ? 32'h0000_0001 : 32'h0000_0000);
    end
    print_verdict();
  end
endmodule
